// *** hdl/iss_pkg.sv ***
package iss_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [8:0] ISS_CTRL_OFFSET   = 9'h100;
    localparam logic [8:0] ISS_STATUS_OFFSET = 9'h104;
    localparam logic [8:0] ISS_TXQ_OFFSET    = 9'h108;
    localparam logic [8:0] ISS_RXQ_OFFSET    = 9'h10C;
    localparam logic [8:0] ISS_ADR_OFFSET    = 9'h110;
    localparam logic [8:0] ISS_TENADR_OFFSET = 9'h11C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ISS_GC_ENABLE_BIT = 6;
    localparam int ISS_TX_EMPTY   = 7;
    localparam int ISS_RX_EMPTY   = 6;
    localparam int ISS_RX_FULL    = 5;
    localparam int ISS_TX_FULL    = 4;
    localparam int ISS_DIR_BIT    = 3;
    localparam int ISS_BUSY_BIT   = 2;
    localparam int ISS_AAT_BIT    = 1;
    localparam int ISS_GC_BIT     = 0;

    // ------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------
    localparam logic [7:0] ISS_STATUS_RESET = 8'h00_C0;
    localparam int         ISS_QUEUE_DEPTH  = 16;
    localparam logic [6:0] ISS_GC_ADDR      = 7'h00_00;
    localparam logic [4:0] ISS_TEN_PREFIX   = 5'h00_1E;

    // Flag group passed from the target front end
    typedef struct packed {
        logic busy;
        logic addressed;
        logic direction;
        logic gc_hit;
    } iss_bus_flags_t;

    // Target front end states
    typedef enum logic [2:0] {
        ISS_IDLE  = 3'b000,
        ISS_ADDR1 = 3'b001,
        ISS_ADDR2 = 3'b011,
        ISS_HOLD  = 3'b010
    } iss_state_t;

endpackage

// *** hdl/iss_bus_watch.sv ***
`timescale 1ns/100ps
// Watches the synchronised bus lines for START, STOP, address match.
module iss_bus_watch
    import iss_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    resetn,
    input  wire logic                    scl_s,
    input  wire logic                    sda_s,
    input  wire logic                    gc_enable,
    input  wire logic                    ten_bit_mode,
    input  wire logic [6:0]              own_addr,
    input  wire logic [2:0]              own_addr_hi,
    output iss_pkg::iss_bus_flags_t      flags
);
    import iss_pkg::*;

    logic       scl_q, scl_d, sda_q, sda_d;
    logic [3:0] bitcnt_q, bitcnt_d;
    logic [7:0] shift_q, shift_d;
    logic       ten_seen_q, ten_seen_d;   // Full 10-bit match seen since the last STOP or 10-bit-mode prefix mismatch
    iss_state_t state_q, state_d;
    iss_bus_flags_t fl_q, fl_d;
    logic start_ev, stop_ev, scl_rise;

    // ------------------------------------------------------------
    // Bus condition detection
    // ------------------------------------------------------------
    assign start_ev = scl_s && scl_q && sda_q && !sda_s;
    assign stop_ev  = scl_s && scl_q && !sda_q && sda_s;
    assign scl_rise = scl_s && !scl_q;

    // Next state: address shifter and flag updates
    always_comb begin
        scl_d    = scl_s;
        sda_d    = sda_s;
        bitcnt_d = bitcnt_q;
        shift_d  = shift_q;
        ten_seen_d = ten_seen_q;
        state_d  = state_q;
        fl_d     = fl_q;
        if (scl_rise && bitcnt_q != 4'h0_8) begin
            shift_d  = {shift_q[6:0], sda_s};
            bitcnt_d = bitcnt_q + 4'h0_1;
        end else if (scl_rise) begin
            bitcnt_d = 4'h0_0;    // Ninth clock is the acknowledge slot
        end
        unique case (state_q)
            ISS_IDLE: begin
            end
            ISS_ADDR1: begin
                if (scl_rise && bitcnt_q == 4'h0_8) begin
                    state_d = ISS_HOLD;
                    if (shift_q[7:1] == ISS_GC_ADDR && !shift_q[0]) begin
                        if (gc_enable) begin
                            fl_d.gc_hit    = 1'b1;
                            fl_d.addressed = 1'b1;
                            fl_d.direction = 1'b0;
                        end
                    end else if (ten_bit_mode) begin
                        // 7-bit matches are ignored here; prefix carries address bits 9 and 8
                        if (shift_q[7:3] == ISS_TEN_PREFIX && shift_q[2:1] == own_addr_hi[2:1]) begin
                            if (!shift_q[0]) begin
                                state_d = ISS_ADDR2;
                            end else if (ten_seen_q) begin
                                // A read after repeated START needs the earlier full match
                                fl_d.addressed = 1'b1;
                                fl_d.direction = 1'b1;
                            end
                        end else begin
                            ten_seen_d = 1'b0;
                        end
                    end else if (shift_q[7:1] == own_addr) begin
                        fl_d.addressed = 1'b1;
                        fl_d.direction = shift_q[0];
                    end
                end
            end
            ISS_ADDR2: begin
                if (scl_rise && bitcnt_q == 4'h0_8) begin
                    state_d = ISS_HOLD;
                    // Second byte holds address bits 7 to 0
                    if (shift_q == {own_addr_hi[0], own_addr}) begin
                        fl_d.addressed = 1'b1;
                        fl_d.direction = 1'b0;
                        ten_seen_d     = 1'b1;
                    end
                end
            end
            ISS_HOLD: begin
            end
        endcase
        if (start_ev) begin
            fl_d.busy      = 1'b1;
            fl_d.addressed = 1'b0;
            fl_d.gc_hit    = 1'b0;
            bitcnt_d       = 4'h0_0;
            state_d        = ISS_ADDR1;
        end
        if (stop_ev) begin
            fl_d.busy      = 1'b0;
            fl_d.addressed = 1'b0;
            ten_seen_d     = 1'b0;
            state_d        = ISS_IDLE;
        end
    end

    // Registers; the flags leave this module straight from flip-flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            bitcnt_q <= 4'h0_0;
            shift_q  <= 8'h00_00;
            ten_seen_q <= 1'b0;
            state_q  <= ISS_IDLE;
            fl_q     <= '0;
        end else begin
            scl_q    <= scl_d;
            sda_q    <= sda_d;
            bitcnt_q <= bitcnt_d;
            shift_q  <= shift_d;
            ten_seen_q <= ten_seen_d;
            state_q  <= state_d;
            fl_q     <= fl_d;
        end
    end

    assign flags = fl_q;

endmodule

// *** hdl/iss_status.sv ***
`timescale 1ns/100ps
// Status word of the two-wire controller, read through the register port.
module iss_status
    import iss_pkg::*;
#(
    parameter int QUEUE_DEPTH = 16
) (
    input  wire logic                         clock,
    input  wire logic                         resetn,
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    input  wire logic [8:0]                   reg_addr,
    input  wire logic                         reg_read,
    input  wire logic                         reg_write,
    input  wire logic [31:0]                  reg_wdata,
    output logic [31:0]                       reg_rdata,
    input  wire logic [$clog2(QUEUE_DEPTH):0] tx_count,
    input  wire logic [$clog2(QUEUE_DEPTH):0] rx_count,
    input  wire logic                         ten_bit_mode,
    input  wire logic [6:0]                   own_addr,
    input  wire logic [2:0]                   own_addr_hi,
    output logic                              target_mode,
    output logic                              general_call_enable
);
    import iss_pkg::*;

    localparam int CW = $clog2(QUEUE_DEPTH) + 1;
    localparam logic [CW-1:0] FULL_COUNT = CW'(QUEUE_DEPTH);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] scl_sync_q, sda_sync_q;
    logic [1:0] scl_sync_d, sda_sync_d;

    always_comb begin
        scl_sync_d = {scl_sync_q[0], scl_in};
        sda_sync_d = {sda_sync_q[0], sda_in};
    end

    // Lines idle high, so reset to 1 to avoid a false START
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scl_sync_q <= 2'b11;
            sda_sync_q <= 2'b11;
        end else begin
            scl_sync_q <= scl_sync_d;
            sda_sync_q <= sda_sync_d;
        end
    end

    // ------------------------------------------------------------
    // Control bit held locally (general call enable)
    // ------------------------------------------------------------
    logic general_call_enable_q, general_call_enable_d;
    iss_bus_flags_t flags;

    always_comb begin
        general_call_enable_d = general_call_enable_q;
        if (reg_write && reg_addr == ISS_CTRL_OFFSET) begin
            general_call_enable_d = reg_wdata[ISS_GC_ENABLE_BIT];
        end
    end

    iss_bus_watch u_watch (
        .clock        (clock),
        .resetn       (resetn),
        .scl_s        (scl_sync_q[1]),
        .sda_s        (sda_sync_q[1]),
        .gc_enable    (general_call_enable_q),
        .ten_bit_mode (ten_bit_mode),
        .own_addr     (own_addr),
        .own_addr_hi  (own_addr_hi),
        .flags        (flags)
    );

    // ------------------------------------------------------------
    // Status word assembly
    // ------------------------------------------------------------
    logic [7:0]  status_q, status_d;
    logic [31:0] rdata_q, rdata_d;
    logic        tmode_q, tmode_d;

    // Queue flags come straight from the counts; no threshold input exists
    always_comb begin
        status_d               = '0;
        status_d[ISS_TX_EMPTY] = (tx_count == '0);
        status_d[ISS_RX_EMPTY] = (rx_count == '0);
        status_d[ISS_RX_FULL]  = (rx_count == FULL_COUNT);
        status_d[ISS_TX_FULL]  = (tx_count == FULL_COUNT);
        status_d[ISS_DIR_BIT]  = flags.addressed & flags.direction;
        status_d[ISS_BUSY_BIT] = flags.busy;
        status_d[ISS_AAT_BIT]  = flags.addressed;
        status_d[ISS_GC_BIT]   = flags.gc_hit;
        tmode_d                = flags.addressed;
    end

    // Read port; writes to the status offset fall through untouched
    always_comb begin
        rdata_d = rdata_q;
        if (reg_read) begin
            unique case (reg_addr)
                ISS_STATUS_OFFSET: rdata_d = {24'h00_0000, status_q};
                ISS_CTRL_OFFSET:   rdata_d = {25'h000_0000, general_call_enable_q, 6'h00};
                default:           rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Flags settle one clock after their event
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            status_q <= ISS_STATUS_RESET;
            rdata_q  <= 32'h0000_0000;
            tmode_q  <= 1'b0;
            general_call_enable_q  <= 1'b0;
        end else begin
            status_q <= status_d;
            rdata_q  <= rdata_d;
            tmode_q  <= tmode_d;
            general_call_enable_q  <= general_call_enable_d;
        end
    end

    assign reg_rdata           = rdata_q;
    assign target_mode         = tmode_q;
    assign general_call_enable = general_call_enable_q;

endmodule

// *** testbench/iss_status_properties.sv ***
`timescale 1ns/100ps
// ------------------------------------------------
// Status word checker
// ------------------------------------------------
module iss_status_properties
    import iss_pkg::*;
#(
    parameter int QUEUE_DEPTH = 16
) (
    input wire logic                         clock,
    input wire logic                         resetn,
    input wire logic [8:0]                   reg_addr,
    input wire logic                         reg_read,
    input wire logic                         reg_write,
    input wire logic [31:0]                  reg_wdata,
    input wire logic [31:0]                  reg_rdata,
    input wire logic [$clog2(QUEUE_DEPTH):0] tx_count,
    input wire logic [$clog2(QUEUE_DEPTH):0] rx_count,
    input wire logic                         general_call_enable,
    input wire logic                         target_mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // Status read; the answer lands one cycle later
    sequence rd_stat_s;
        reg_read && reg_addr == ISS_STATUS_OFFSET;
    endsequence
    // Read of a place that holds nothing
    sequence rd_void_s;
        reg_read && reg_addr != ISS_STATUS_OFFSET && reg_addr != ISS_CTRL_OFFSET;
    endsequence
    // Counts enter the word one clock before the read takes it, hence depth 2
    tx_empty_a: assert property (rd_stat_s |=> reg_rdata[7] == ($past(tx_count, 2) == 0))
        else $error("tx empty flag wrong");
    rx_empty_a: assert property (rd_stat_s |=> reg_rdata[6] == ($past(rx_count, 2) == 0))
        else $error("rx empty flag wrong");
    rx_full_a: assert property (rd_stat_s |=> reg_rdata[5] == ($past(rx_count, 2) == QUEUE_DEPTH))
        else $error("rx full flag wrong");
    tx_full_a: assert property (rd_stat_s |=> reg_rdata[4] == ($past(tx_count, 2) == QUEUE_DEPTH))
        else $error("tx full flag wrong");
    reserved_zero_a: assert property (rd_stat_s |=> reg_rdata[31:8] == 24'h00_0000)
        else $error("reserved status bits set");
    void_zero_a: assert property (rd_void_s |=> reg_rdata == 32'h0000_0000)
        else $error("empty place read nonzero");
    dir_addr_a: assert property (rd_stat_s |=> !reg_rdata[3] || reg_rdata[1])
        else $error("direction shown while not addressed");
    tmode_flag_a: assert property (rd_stat_s |=> reg_rdata[1] == $past(target_mode))
        else $error("target mode differs from addressed flag");
    gc_write_a: assert property (reg_write && reg_addr == ISS_CTRL_OFFSET
        |=> general_call_enable == $past(reg_wdata[6]))
        else $error("general call enable not stored");
endmodule

bind iss_status iss_status_properties #(.QUEUE_DEPTH(QUEUE_DEPTH)) i_props (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_read(reg_read),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_count(tx_count),
    .rx_count(rx_count), .general_call_enable(general_call_enable), .target_mode(target_mode)
);

// *** testbench/iss_bus_initiator.sv ***
`timescale 1ns/100ps
// ------------------------------------------------
// Remote initiator; lines rest on pull-ups when released
// ------------------------------------------------
module iss_bus_initiator (
    output logic scl_oe_n,
    output logic sda_oe_n
);
    localparam realtime Q = 31.25; // Quarter of the 125 ns bus period
    // Clock stands still high between frames
    initial begin
        scl_oe_n = 1'b1;
        sda_oe_n = 1'b1;
    end
    // Serves as first or repeated START
    task automatic start();
        sda_oe_n = 1'b1;
        #Q scl_oe_n = 1'b1;
        #Q sda_oe_n = 1'b0;
        #Q scl_oe_n = 1'b0;
        #Q;
    endtask
    task automatic bit_out(input logic b);
        sda_oe_n = b;
        #Q scl_oe_n = 1'b1;
        #(2 * Q) scl_oe_n = 1'b0;
        #Q;
    endtask
    // Eight bits first-most-significant, then a released acknowledge slot
    task automatic wbyte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            bit_out(v[i]);
        end
        bit_out(1'b1);
    endtask
    task automatic stop();
        sda_oe_n = 1'b0;
        #Q scl_oe_n = 1'b1;
        #Q sda_oe_n = 1'b1;
        #(2 * Q);
    endtask
endmodule

// *** testbench/tb_iss_status.sv ***
`timescale 1ns/100ps
// ------------------------------------------------
// Status word bench
// ------------------------------------------------
module tb_iss_status;
    import iss_pkg::*;
    logic        clock, resetn, reg_read, reg_write, ten_bit_mode, pend;
    logic        scl_oe_n, sda_oe_n, target_mode, general_call_enable;
    logic [8:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, got_e;
    logic [4:0]  tx_count, rx_count;
    logic [6:0]  own_addr;
    logic [2:0]  own_addr_hi;
    logic [31:0] exp_q[$];
    int          error_cnt, total_checks;
    int          lv[4] = '{0, 1, 15, 16};
    wire         scl_w = scl_oe_n; // Released line rests high on its pull-up
    wire         sda_w = sda_oe_n;

    iss_status #(.QUEUE_DEPTH(ISS_QUEUE_DEPTH)) i_dut (
        .clock(clock), .resetn(resetn), .scl_in(scl_w), .sda_in(sda_w), .reg_addr(reg_addr),
        .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .tx_count(tx_count), .rx_count(rx_count), .ten_bit_mode(ten_bit_mode), .own_addr(own_addr),
        .own_addr_hi(own_addr_hi), .target_mode(target_mode), .general_call_enable(general_call_enable)
    );
    iss_bus_initiator i_init (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    // One read; the expectation waits in the queue for the monitor
    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        reg_addr = a;
        reg_read = 1'b1;
        exp_q.push_back(e);
        tick();
        reg_read = 1'b0;
        tick();
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        tick();
        reg_write = 1'b0;
        tick();
    endtask
    // Bus flags need about four clocks to cross; eight leaves margin
    task automatic st(input logic [3:0] f);
        repeat (8) tick();
        total_checks++;
        if (target_mode !== f[1]) begin
            error_cnt++;
            $display("[ERR] target_mode expected %b seen %b", f[1], target_mode);
        end
        rd(ISS_STATUS_OFFSET, {24'h00_0000, 4'hC, f});
    endtask
    task automatic test_done();
        if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Read data is taken one edge after the read strobe
    always @(posedge clock) begin
        if (pend) begin
            got_e = exp_q.pop_front();
            total_checks++;
            if (reg_rdata !== got_e) begin
                error_cnt++;
                $display("[ERR] reg_rdata expected %h seen %h", got_e, reg_rdata);
            end
        end
        pend = reg_read;
    end
    initial begin
        #400us;
        error_cnt++;
        test_done();
    end
    initial begin
        {resetn, reg_read, reg_write, ten_bit_mode, pend} = '0;
        {reg_addr, reg_wdata, tx_count, rx_count, own_addr, own_addr_hi} = '0;
        void'($urandom(96959));
        own_addr = 7'($urandom_range(8, 119)); // Clear of general call and 10-bit prefix
        own_addr_hi = 3'($urandom());
        repeat (2) @(posedge clock);
        #1 resetn = 1'b1;
        rd(ISS_STATUS_OFFSET, 32'h0000_00C0);
        rd(ISS_CTRL_OFFSET, 32'h0000_0000);
        // Boundary fill levels first, then random ones
        for (int i = 0; i < 16; i++) begin
            tx_count = (i < 4) ? 5'(lv[i]) : 5'($urandom_range(0, 16));
            rx_count = (i < 4) ? 5'(lv[3 - i]) : 5'($urandom_range(0, 16));
            tick();
            rd(ISS_STATUS_OFFSET, {24'h00_0000, tx_count == 0, rx_count == 0, rx_count == 16, tx_count == 16, 4'h0});
        end
        tx_count = 5'h0_0;
        rx_count = 5'h0_0;
        wr(ISS_STATUS_OFFSET, 32'hFFFF_FFFF);
        rd(ISS_STATUS_OFFSET, 32'h0000_00C0);
        rd(9'h1F0, 32'h0000_0000);
        wr(ISS_CTRL_OFFSET, 32'h0000_0040);
        rd(ISS_CTRL_OFFSET, 32'h0000_0040);
        i_init.start();
        st(4'b0100);
        i_init.wbyte({own_addr, 1'b0});
        st(4'b0110);
        i_init.start();
        st(4'b0100);
        i_init.wbyte({own_addr, 1'b1});
        st(4'b1110);
        i_init.stop();
        st(4'b0000);
        i_init.start();
        i_init.wbyte(8'h00);
        st(4'b0111);
        i_init.stop();
        wr(ISS_CTRL_OFFSET, 32'h0000_0000);
        i_init.start();
        i_init.wbyte(8'h00);
        st(4'b0100);
        i_init.start();
        i_init.wbyte({own_addr ^ 7'h01, 1'b0});
        st(4'b0100);
        ten_bit_mode = 1'b1;
        i_init.start();
        i_init.wbyte({own_addr, 1'b0});
        st(4'b0100);
        wr(ISS_CTRL_OFFSET, 32'h0000_0040);
        i_init.start();
        i_init.wbyte(8'h00);
        st(4'b0111);
        i_init.stop();
        // Full 10-bit write address, then a read after repeated START
        i_init.start();
        i_init.wbyte({5'b11110, own_addr_hi[2:1], 1'b0});
        i_init.wbyte({own_addr_hi[0], own_addr});
        st(4'b0110);
        i_init.start();
        st(4'b0100);
        i_init.wbyte({5'b11110, own_addr_hi[2:1], 1'b1});
        st(4'b1110);
        i_init.stop();
        st(4'b0000);
        test_done();
    end
endmodule
